// [dv/sbsr_bus_ctrl.sv]
/*
 Bus controller model: issues common-command strobes to the status block.
 Assumes the block samples strobes on the rising edge of ref_clk.
*/
`timescale 1ns/1ns

module sbsr_bus_ctrl (
    input wire logic ref_clk,
    output logic sreWrite,
    output logic [7:0] sreWrData,
    output logic sreRead,
    output logic stbRead,
    output logic clsCmd,
    output logic trgCmd,
    output logic tstQuery,
    output logic waiCmd
);
    // Idle bus at time zero
    initial begin
        {sreWrite, sreRead, stbRead, clsCmd, trgCmd, tstQuery, waiCmd} = '0;
        sreWrData = 8'h00;
    end

    // One strobe for one cycle; the gap cycle after it avoids a double drive
    task automatic send(input int op, input logic [7:0] d);
        @(negedge ref_clk);
        sreWrData = d;
        case (op)
            0: sreWrite = 1'b1;
            1: sreRead = 1'b1;
            2: stbRead = 1'b1;
            3: clsCmd = 1'b1;
            4: trgCmd = 1'b1;
            5: tstQuery = 1'b1;
            default: waiCmd = 1'b1;
        endcase
        @(negedge ref_clk);
        {sreWrite, sreRead, stbRead, clsCmd, trgCmd, tstQuery, waiCmd} = '0;
        // Released data lines must not look valid
        sreWrData = ~d;
    endtask
endmodule

// [dv/tb_status_byte_service_request.sv]
/*
 Self-checking bench for the status byte and service request block.
 Assumes the constants header and package are compiled first.
*/
`timescale 1ns/1ns
`include "sbsr_regs.svh"

module tb_status_byte_service_request;
    localparam int NCH = 2;
    localparam logic [63:0] TCYC = 64'd20; // Short self-test
    localparam int SW = 0, SR = 1, ST = 2, CL = 3, TG = 4, TS = 5, WA = 6;
    logic ref_clk, rst, sreWrite, sreRead, stbRead, clsCmd, trgCmd, tstQuery, waiCmd;
    logic [7:0] sreWrData, rdData, testResult, v, m;
    logic devClear, devEvt, quesEvt, esbEvt, operEvt, errQueueNotEmpty, msgAvail;
    logic trigSrcBus, ddtDefined, opsPending, testFail;
    logic [NCH-1:0] chanWaiting, trigStart;
    logic rdValid, srqActive, errValid, ddtStart, testValid, statusClear, cmdHold;
    logic signed [15:0] errCode;
    logic [3:0] tc [5] = '{4'b0001, 4'b0100, 4'b0110, 4'b0111, 4'b1101}; // {ddt,bus,w}
    logic [23:0] expQ [$]; // Notes of {kind, value}
    int failures, comparisons, b;
    int bits [6] = '{1, 2, 3, 4, 5, 7};

    sbsr_bus_ctrl bus (.ref_clk(ref_clk), .sreWrite(sreWrite), .sreWrData(sreWrData),
        .sreRead(sreRead), .stbRead(stbRead), .clsCmd(clsCmd), .trgCmd(trgCmd),
        .tstQuery(tstQuery), .waiCmd(waiCmd));

    sbsr_status_ctrl #(.NUM_CHAN(NCH), .TEST_CYCLES(TCYC)) DUT (.ref_clk(ref_clk),
        .rst(rst), .sreWrite(sreWrite), .sreWrData(sreWrData), .sreRead(sreRead),
        .stbRead(stbRead), .clsCmd(clsCmd), .trgCmd(trgCmd), .tstQuery(tstQuery),
        .waiCmd(waiCmd), .devClear(devClear), .devEvt(devEvt), .quesEvt(quesEvt),
        .esbEvt(esbEvt), .operEvt(operEvt), .errQueueNotEmpty(errQueueNotEmpty),
        .msgAvail(msgAvail), .trigSrcBus(trigSrcBus), .chanWaiting(chanWaiting),
        .ddtDefined(ddtDefined), .opsPending(opsPending), .testFail(testFail),
        .rdData(rdData), .rdValid(rdValid), .srqActive(srqActive), .errValid(errValid),
        .errCode(errCode), .trigStart(trigStart), .ddtStart(ddtStart),
        .testResult(testResult), .testValid(testValid), .statusClear(statusClear),
        .cmdHold(cmdHold));

    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic note(input logic [7:0] k, input logic [15:0] val);
        expQ.push_back({k, val});
    endtask

    // Oldest note against each result; an unasked result is a mismatch
    task automatic take(input logic [7:0] k, input logic [15:0] val, input string what);
        if (expQ.size() == 0) begin
            check({what, " unasked"}, 24'hFFFFFF, {k, val});
        end else begin
            check(what, expQ.pop_front(), {k, val});
        end
    endtask

    // Result watcher; outputs are registered so the falling edge is settled
    always @(negedge ref_clk) begin
        if (rst === 1'b0) begin
            if (rdValid === 1'b1) take(8'h00, {8'h00, rdData}, "rdData");
            if (errValid === 1'b1) take(8'h01, errCode, "errCode");
            if (trigStart !== '0) take(8'h02, 16'(trigStart), "trigStart");
            if (ddtStart === 1'b1) take(8'h03, 16'h0001, "ddtStart");
            if (testValid === 1'b1) take(8'h04, {8'h00, testResult}, "testResult");
            if (statusClear === 1'b1) take(8'h05, 16'h0001, "statusClear");
        end
    end

    // Bounded wait for all noted results
    task automatic settle(input string name);
        int n;
        n = 0;
        while (expQ.size() != 0 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        check("pending results", 24'h000000, 24'(expQ.size()));
        expQ.delete();
        $display("test %s done", name);
    endtask

    // Raise one status condition: pulse for sticky bits, level for queues
    task automatic set_cond(input int bit_n);
        @(negedge ref_clk);
        case (bit_n)
            1: devEvt = 1'b1;
            2: errQueueNotEmpty = 1'b1;
            3: quesEvt = 1'b1;
            4: msgAvail = 1'b1;
            5: esbEvt = 1'b1;
            default: operEvt = 1'b1;
        endcase
        @(negedge ref_clk);
        {devEvt, quesEvt, esbEvt, operEvt} = '0;
    endtask

    task automatic final_report;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of about two hundred cycles
    initial begin
        #(8 * 20000);
        failures++;
        $display("watchdog expired");
        final_report();
    end

    initial begin
        rst = 1'b1;
        {devClear, devEvt, quesEvt, esbEvt, operEvt, errQueueNotEmpty, msgAvail} = '0;
        {trigSrcBus, ddtDefined, opsPending, testFail} = '0;
        chanWaiting = '0;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        void'($urandom(67));
        // Mask write and read back, bit 6 never kept
        note(8'h00, 16'h0000);
        bus.send(SR, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hFF : 8'($urandom);
            bus.send(SW, v);
            note(8'h00, {8'h00, v & `SBSR_MASK_NO_MSS});
            bus.send(SR, 8'h00);
        end
        settle("mask");
        // Each status bit alone, masked then enabled
        foreach (bits[j]) begin
            b = bits[j];
            note(8'h05, 16'h0001);
            bus.send(CL, 8'h00);
            set_cond(b);
            m = 8'($urandom) & `SBSR_MASK_NO_MSS & ~8'(1 << b);
            bus.send(SW, m);
            check("srqActive masked", 24'h0, {23'h0, srqActive});
            note(8'h00, 16'(1 << b));
            bus.send(ST, 8'h00);
            bus.send(SW, m | 8'(1 << b));
            check("srqActive enabled", 24'h1, {23'h0, srqActive});
            note(8'h00, 16'(1 << b) | 16'h0040);
            bus.send(ST, 8'h00);
            @(negedge ref_clk);
            {errQueueNotEmpty, msgAvail} = '0;
        end
        @(negedge ref_clk);
        {devEvt, quesEvt, esbEvt, operEvt} = '1;
        @(negedge ref_clk);
        {devEvt, quesEvt, esbEvt, operEvt} = '0;
        note(8'h05, 16'h0001);
        bus.send(CL, 8'h00);
        note(8'h00, 16'h0000);
        bus.send(ST, 8'h00);
        settle("status");
        // Trigger outcomes: source, nothing waiting, start, device action
        foreach (tc[j]) begin
            @(negedge ref_clk);
            {ddtDefined, trigSrcBus, chanWaiting} = tc[j];
            if (!tc[j][2] || tc[j][1:0] == 2'b00) begin
                note(8'h01, `SBSR_ERR_TRIG_IGNORED);
            end else if (tc[j][3]) begin
                note(8'h03, 16'h0001);
            end else begin
                note(8'h02, 16'(tc[j][1:0]));
            end
            bus.send(TG, 8'h00);
        end
        settle("trigger");
        // Self-test pass then fail; a read while busy is refused
        for (int f = 0; f < 2; f++) begin
            testFail = f[0];
            note(8'h04, f[0] ? 16'(`SBSR_TEST_FAIL) : 16'(`SBSR_TEST_PASS));
            bus.send(TS, 8'h00);
            check("cmdHold in test", 24'h1, {23'h0, cmdHold});
            bus.send(ST, 8'h00);
            settle("selftest");
            check("cmdHold after test", 24'h0, {23'h0, cmdHold});
        end
        // Wait barrier: refused write, release by device clear then by completion
        opsPending = 1'b1;
        bus.send(WA, 8'h00);
        bus.send(SW, 8'h3C);
        repeat (5) @(negedge ref_clk);
        check("cmdHold in wait", 24'h1, {23'h0, cmdHold});
        devClear = 1'b1;
        @(negedge ref_clk);
        devClear = 1'b0;
        repeat (2) @(negedge ref_clk);
        check("cmdHold after clear", 24'h0, {23'h0, cmdHold});
        bus.send(WA, 8'h00);
        opsPending = 1'b0;
        repeat (3) @(negedge ref_clk);
        check("cmdHold after ops", 24'h0, {23'h0, cmdHold});
        // Last mask written is the final enabled pass of the status test
        note(8'h00, {8'h00, (m | 8'(1 << b)) & `SBSR_MASK_NO_MSS});
        bus.send(SR, 8'h00);
        settle("wait");
        final_report();
    end
endmodule

// [rtl/sbsr_pkg.sv]
/*
 Types of the status byte and service request block.
 Assumes the constants header is on the include path.
*/
`include "sbsr_regs.svh"

package sbsr_pkg;
    // Sequencer states; idle-test differs in one bit, idle-wait in two
    typedef enum logic [1:0] {
        SBSR_IDLE = 2'b00,
        SBSR_TEST = 2'b01,
        SBSR_WAIT = 2'b11
    } sbsr_state_t;

    // Whole state of the main module
    typedef struct packed {
        sbsr_state_t state;
        logic [7:0] sre;
        logic devS;
        logic quesS;
        logic esbS;
        logic operS;
        logic [7:0] rdData;
        logic rdValid;
        logic errValid;
        logic [`SBSR_MAX_CHAN-1:0] trigPulse;
        logic ddtPulse;
        logic [7:0] testRes;
        logic testValid;
        logic clearPulse;
    } sbsr_regs_t;
endpackage

// [rtl/sbsr_regs.svh]
/*
 Status byte and service request constants: bit positions, reset values,
 error code and self-test timing. Assumes inclusion by bare name only.
*/
`ifndef SBSR_REGS_SVH
`define SBSR_REGS_SVH

// Status byte bit positions
`define SBSR_BIT_SPARE 0
`define SBSR_BIT_DEV 1
`define SBSR_BIT_ERRQ 2
`define SBSR_BIT_QUES 3
`define SBSR_BIT_MAV 4
`define SBSR_BIT_ESB 5
`define SBSR_BIT_MSS 6
`define SBSR_BIT_OPER 7

// Bits that take part in the summary and in the enable mask
`define SBSR_MASK_NO_MSS 8'hBF
// Enable mask after reset
`define SBSR_SRE_RESET 8'h00
// Trigger ignored error code
`define SBSR_ERR_TRIG_IGNORED (-16'sd211)
// Self-test duration in seconds and clock rate in Hz
`define SBSR_TEST_SECONDS 30
`define SBSR_CLK_HZ 125000000
// Self-test length in clock cycles
`define SBSR_TEST_CYCLES (64'd`SBSR_TEST_SECONDS * 64'd`SBSR_CLK_HZ)
// Widest channel vector held in the state record
`define SBSR_MAX_CHAN 8
// Self-test answers
`define SBSR_TEST_PASS 8'h00
`define SBSR_TEST_FAIL 8'h01

`endif

// [rtl/sbsr_status_ctrl.sv]
/*
 Status byte, service request summary, trigger command, self-test and wait
 barrier of a common-command interface. Assumes a command parser that
 issues one-cycle command strobes synchronous to ref_clk, and queue logic
 outside that reports its own non-empty levels.
*/
`timescale 1ns/1ns
`include "sbsr_regs.svh"

module sbsr_status_ctrl #(
    parameter int NUM_CHAN = 2,
    parameter logic [63:0] TEST_CYCLES = `SBSR_TEST_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sreWrite,
    input wire logic [7:0] sreWrData,
    input wire logic sreRead,
    input wire logic stbRead,
    input wire logic clsCmd,
    input wire logic trgCmd,
    input wire logic tstQuery,
    input wire logic waiCmd,
    input wire logic devClear,
    input wire logic devEvt,
    input wire logic quesEvt,
    input wire logic esbEvt,
    input wire logic operEvt,
    input wire logic errQueueNotEmpty,
    input wire logic msgAvail,
    input wire logic trigSrcBus,
    input wire logic [NUM_CHAN-1:0] chanWaiting,
    input wire logic ddtDefined,
    input wire logic opsPending,
    input wire logic testFail,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic srqActive,
    output logic errValid,
    output logic signed [15:0] errCode,
    output logic [NUM_CHAN-1:0] trigStart,
    output logic ddtStart,
    output logic [7:0] testResult,
    output logic testValid,
    output logic statusClear,
    output logic cmdHold
);
    import sbsr_pkg::*;

    sbsr_regs_t st_r; // Registered state
    sbsr_regs_t st_nxt; // Next state
    logic [7:0] statusByte; // Live status byte, bit 6 not yet filled
    logic mss; // Master summary
    logic tmrDone; // Self-test finished pulse
    logic tmrRun; // Self-test in progress
    logic cmdOk; // Commands accepted this cycle
    logic [NUM_CHAN-1:0] chanW; // Waiting channels

    if (NUM_CHAN < 1 || NUM_CHAN > `SBSR_MAX_CHAN) begin : g_chk
        $error("sbsr_status_ctrl: NUM_CHAN out of range");
    end

    // Summary over the masked status byte, bit 6 excluded
    function automatic logic summary(input logic [7:0] sb, input logic [7:0] en);
        summary = |(sb & en & `SBSR_MASK_NO_MSS);
    endfunction

    assign chanW = chanWaiting;

    // Live status byte from sticky and level conditions
    always_comb begin
        statusByte = 8'h00; // Bit 0 stays zero
        statusByte[`SBSR_BIT_DEV] = st_r.devS;
        statusByte[`SBSR_BIT_ERRQ] = errQueueNotEmpty;
        statusByte[`SBSR_BIT_QUES] = st_r.quesS;
        statusByte[`SBSR_BIT_MAV] = msgAvail;
        statusByte[`SBSR_BIT_ESB] = st_r.esbS;
        statusByte[`SBSR_BIT_OPER] = st_r.operS;
    end

    assign mss = summary(statusByte, st_r.sre);

    // Commands are only taken with no barrier or self-test open
    assign cmdOk = (st_r.state == SBSR_IDLE) && !tmrRun;

    sbsr_test_timer #(
        .CYCLES(TEST_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(cmdOk && tstQuery),
        .running(tmrRun),
        .done(tmrDone)
    );

    // Next state for every register of the block
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdValid = 1'b0;
        st_nxt.errValid = 1'b0;
        st_nxt.trigPulse = '0;
        st_nxt.ddtPulse = 1'b0;
        st_nxt.testValid = 1'b0;
        st_nxt.clearPulse = 1'b0;
        // Clear first, so a same-cycle event below still lands
        if (cmdOk && clsCmd) begin
            st_nxt.devS = 1'b0;
            st_nxt.quesS = 1'b0;
            st_nxt.esbS = 1'b0;
            st_nxt.operS = 1'b0;
            st_nxt.clearPulse = 1'b1; // Empties outside queues
        end
        // Events set sticky summaries; set wins over clear
        if (devEvt) begin
            st_nxt.devS = 1'b1;
        end
        if (quesEvt) begin
            st_nxt.quesS = 1'b1;
        end
        if (esbEvt) begin
            st_nxt.esbS = 1'b1;
        end
        if (operEvt) begin
            st_nxt.operS = 1'b1;
        end
        case (st_r.state)
            SBSR_IDLE: begin
                if (sreWrite) begin
                    st_nxt.sre = sreWrData & `SBSR_MASK_NO_MSS;
                end
                if (sreRead) begin
                    st_nxt.rdData = st_r.sre & `SBSR_MASK_NO_MSS;
                    st_nxt.rdValid = 1'b1;
                end else if (stbRead) begin
                    st_nxt.rdData = statusByte;
                    st_nxt.rdData[`SBSR_BIT_MSS] = mss;
                    st_nxt.rdData[`SBSR_BIT_SPARE] = 1'b0;
                    st_nxt.rdValid = 1'b1;
                end
                if (trgCmd) begin
                    if (!trigSrcBus || chanW == '0) begin
                        st_nxt.errValid = 1'b1;
                    end else if (ddtDefined) begin
                        st_nxt.ddtPulse = 1'b1;
                    end else begin
                        // Same path as a bus group trigger
                        st_nxt.trigPulse[NUM_CHAN-1:0] = chanW;
                    end
                end
                if (tstQuery) begin
                    st_nxt.state = SBSR_TEST;
                end else if (waiCmd) begin
                    st_nxt.state = SBSR_WAIT;
                end
            end
            SBSR_TEST: begin
                // Long test; nothing else runs meanwhile
                if (tmrDone) begin
                    st_nxt.testRes = testFail ? `SBSR_TEST_FAIL : `SBSR_TEST_PASS;
                    st_nxt.testValid = 1'b1;
                    st_nxt.state = SBSR_IDLE;
                end
            end
            SBSR_WAIT: begin
                // Released by completion or by device clear
                if (!opsPending || devClear) begin
                    st_nxt.state = SBSR_IDLE;
                end
            end
            default: begin
                st_nxt.state = SBSR_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.sre <= `SBSR_SRE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign rdData = st_r.rdData;
    assign rdValid = st_r.rdValid;
    assign srqActive = mss;
    assign errValid = st_r.errValid;
    assign errCode = st_r.errValid ? `SBSR_ERR_TRIG_IGNORED : 16'sh0000;
    assign trigStart = st_r.trigPulse[NUM_CHAN-1:0];
    assign ddtStart = st_r.ddtPulse;
    assign testResult = st_r.testRes;
    assign testValid = st_r.testValid;
    assign statusClear = st_r.clearPulse;
    assign cmdHold = (st_r.state != SBSR_IDLE);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_sre_bit6;
        sreRead && cmdOk |=> rdValid && !rdData[6];
    endproperty
    a_sre_bit6: assert property (p_sre_bit6) else $error("mask read bit 6 set");

    property p_stb_mss;
        stbRead && !sreRead && cmdOk |=> rdData[6] == $past(mss) && !rdData[0];
    endproperty
    a_stb_mss: assert property (p_stb_mss) else $error("status read summary wrong");

    property p_mss_calc;
        srqActive == (|(statusByte[5:0] & st_r.sre[5:0]) || (statusByte[7] && st_r.sre[7]));
    endproperty
    a_mss_calc: assert property (p_mss_calc) else $error("summary wrong");

    property p_dev_set;
        devEvt |=> statusByte[1];
    endproperty
    a_dev_set: assert property (p_dev_set) else $error("device bit not set");

    property p_oper_set;
        operEvt |=> statusByte[7];
    endproperty
    a_oper_set: assert property (p_oper_set) else $error("operation bit not set");

    property p_trg_err;
        trgCmd && cmdOk && (!trigSrcBus || chanWaiting == '0)
            |=> errValid && errCode == -16'sd211 && trigStart == '0 && !ddtStart;
    endproperty
    a_trg_err: assert property (p_trg_err) else $error("trigger error missing");

    property p_trg_go;
        trgCmd && cmdOk && trigSrcBus && chanWaiting != '0 && !ddtDefined
            |=> trigStart == $past(chanWaiting) && !errValid;
    endproperty
    a_trg_go: assert property (p_trg_go) else $error("trigger not issued");

    property p_ddt;
        trgCmd && cmdOk && trigSrcBus && chanWaiting != '0 && ddtDefined
            |=> ddtStart && trigStart == '0;
    endproperty
    a_ddt: assert property (p_ddt) else $error("device trigger not taken");

    property p_wai_hold;
        (waiCmd && !tstQuery && cmdOk) || (st_r.state == SBSR_WAIT && opsPending && !devClear)
            |=> cmdHold;
    endproperty
    a_wai_hold: assert property (p_wai_hold) else $error("wait released early");

    property p_wai_end;
        cmdHold && st_r.state == SBSR_WAIT && !opsPending |=> !cmdHold;
    endproperty
    a_wai_end: assert property (p_wai_end) else $error("wait not released");

    property p_cls;
        clsCmd && cmdOk && !devEvt |=> statusClear && !statusByte[1];
    endproperty
    a_cls: assert property (p_cls) else $error("clear status failed");

    property p_test_done;
        tmrDone |=> testValid && testResult == ($past(testFail) ? 8'h01 : 8'h00) && !cmdHold;
    endproperty
    a_test_done: assert property (p_test_done) else $error("self-test result wrong");

    c_srq: cover property (mss && st_r.sre[`SBSR_BIT_MAV] && msgAvail);
    c_trig: cover property (trigStart != '0);
    c_wait: cover property (st_r.state == SBSR_WAIT ##1 !cmdHold);
    c_test: cover property (testValid);
endmodule

// [rtl/sbsr_test_timer.sv]
/*
 Self-test duration counter: counts a fixed number of cycles after start
 and pulses done. Assumes start is a one-cycle pulse on ref_clk.
*/
`timescale 1ns/1ns
`include "sbsr_regs.svh"

module sbsr_test_timer #(
    parameter logic [63:0] CYCLES = `SBSR_TEST_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    output logic running,
    output logic done
);
    import sbsr_pkg::*;

    typedef struct packed {
        logic [63:0] cnt;
        logic run;
        logic done;
    } sbsr_tmr_t;

    sbsr_tmr_t tmr_r; // Registered timer state
    sbsr_tmr_t tmr_nxt; // Next timer state

    if (CYCLES < 64'd1) begin : g_chk
        $error("sbsr_test_timer: CYCLES must be at least one");
    end

    // Count down; start while running is ignored
    always_comb begin
        tmr_nxt = tmr_r;
        tmr_nxt.done = 1'b0;
        if (tmr_r.run) begin
            if (tmr_r.cnt == 64'd1) begin
                tmr_nxt.run = 1'b0; // Last cycle of the test
                tmr_nxt.done = 1'b1;
            end else begin
                tmr_nxt.cnt = tmr_r.cnt - 64'd1;
            end
        end else if (start) begin
            tmr_nxt.run = 1'b1;
            tmr_nxt.cnt = CYCLES;
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tmr_r <= '0;
        end else begin
            tmr_r <= tmr_nxt;
        end
    end

    assign running = tmr_r.run;
    assign done = tmr_r.done;
endmodule
